// >>> rtl/uefc_top.v
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "uefc_map.vh"
// Enhanced feature control for one UART channel
module uefc_top
#(
  parameter FIFO_W = 7
)
(
  input wire clk,
  input wire rst_b,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire cts_in_b,
  input wire dsr_in_b,
  output reg rts_out_b,
  output reg dtr_out_b,
  output wire tx_stall,
  input wire [FIFO_W-1:0] rx_fill,
  input wire [FIFO_W-1:0] rx_halt_lvl,
  input wire [FIFO_W-1:0] rx_resume_lvl,
  input wire rx_valid,
  input wire [7:0] rx_char,
  input wire [7:0] second_stop_char,
  output reg rx_store,
  output reg [7:0] rx_store_data,
  output reg rx_flow_stop,
  input wire sleep_req,
  output reg sleep_active,
  output reg [1:0] tx_flow_sel,
  output reg [1:0] rx_flow_sel
);
  reg [7:0] feat_q;
  reg [7:0] ier_q;
  reg [7:0] isr_q;
  reg [7:0] fcr_q;
  reg [7:0] mcr_q;
  reg [7:0] msr_q;
  reg [7:0] asr_q;
  reg auto_rts_q;
  wire enh;
  wire auto_in;
  wire auto_out;
  wire pair_dsr;
  wire rx_cmp_stop2;
  wire m_store;
  wire m_special;
  wire m_stop;
  wire in_hold;

  assign enh = feat_q[`UEFC_BIT_ENH];
  assign auto_in = feat_q[`UEFC_BIT_AUTO_IN];
  assign auto_out = feat_q[`UEFC_BIT_AUTO_OUT];
  assign pair_dsr = mcr_q[`UEFC_BIT_PAIRSEL];
  // Receive side compares the second set when low pair has bit 0 set
  assign rx_cmp_stop2 = feat_q[`UEFC_BIT_RXCMP2];

  // Masked write: protected bits keep old value unless enhanced mode
  function [7:0] mwr;
    input [7:0] old;
    input [7:0] nw;
    input [7:0] msk;
    input en;
    begin
      if (en)
        mwr = nw;
      else
        mwr = (old & msk) | (nw & ~msk);
    end
  endfunction

  uefc_char_match u_match
  (
    .rx_char(rx_char),
    .second_stop_char(second_stop_char),
    .special_en(feat_q[`UEFC_BIT_SPECIAL]),
    .rx_cmp_stop2(rx_cmp_stop2),
    .store(m_store),
    .special_hit(m_special),
    .stop_hit(m_stop)
  );

  // Selected modem input asserted low means remote is ready
  assign in_hold = pair_dsr ? dsr_in_b : cts_in_b;
  assign tx_stall = auto_in & in_hold;

  // Register writes and status flags; hardware set beats software clear
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      feat_q <= `UEFC_RST_BYTE;
      ier_q <= `UEFC_RST_BYTE;
      isr_q <= `UEFC_RST_BYTE;
      fcr_q <= `UEFC_RST_BYTE;
      mcr_q <= `UEFC_RST_BYTE;
      msr_q <= `UEFC_RST_BYTE;
      asr_q <= `UEFC_RST_BYTE;
    end
    else
    begin
      // Feature byte itself is never protected, so the unlock bit is reachable
      if (wr)
      begin
        if (addr == `UEFC_OFS_FEAT)
          feat_q <= wdata;
        else if (addr == `UEFC_OFS_IER)
          ier_q <= mwr(ier_q, wdata, `UEFC_MASK_IER, enh);
        else if (addr == `UEFC_OFS_FCR)
          fcr_q <= mwr(fcr_q, wdata, `UEFC_MASK_FCR, enh);
        else if (addr == `UEFC_OFS_MCR)
          mcr_q <= mwr(mcr_q, wdata, `UEFC_MASK_MCR, enh);
        else if (addr == `UEFC_OFS_MSR)
          msr_q <= mwr(msr_q, wdata, `UEFC_MASK_MSR, enh);
        else if (addr == `UEFC_OFS_ASR)
          asr_q <= mwr(asr_q, wdata, `UEFC_MASK_ASR, enh);
      end
      // Status flag bits: write clears via zero, only under enhanced mode
      if (wr && addr == `UEFC_OFS_ISR)
        isr_q <= mwr(isr_q, wdata, `UEFC_MASK_ISR, enh);
      if (rx_valid && m_special)
        isr_q[`UEFC_BIT_SPEC_FLAG] <= 1'b1;
      if (rx_valid && m_stop)
        isr_q[`UEFC_BIT_STOP_FLAG] <= 1'b1;
    end
  end

  // Received character path and flow-control outputs
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_store <= 1'b0;
      rx_store_data <= `UEFC_RST_BYTE;
      rx_flow_stop <= 1'b0;
      tx_flow_sel <= 2'h0;
      rx_flow_sel <= 2'h0;
    end
    else
    begin
      rx_store <= rx_valid & m_store;
      // Data register follows every valid character, stored or not
      if (rx_valid)
        rx_store_data <= rx_char;
      rx_flow_stop <= rx_valid & m_stop;
      tx_flow_sel <= feat_q[`UEFC_TXSEL_HI:`UEFC_TXSEL_LO];
      rx_flow_sel <= feat_q[`UEFC_RXSEL_HI:`UEFC_RXSEL_LO];
    end
  end

  // Auto output with hysteresis, so the line does not chatter near level
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      auto_rts_q <= 1'b0;
      rts_out_b <= 1'b1;
      dtr_out_b <= 1'b1;
    end
    else
    begin
      // Resume level must sit at least two below halt level, or the flag just tracks the halt compare
      // Halt check wins when both hold, so an overfull FIFO always stops
      if (rx_fill >= rx_halt_lvl)
        auto_rts_q <= 1'b1;
      else if (rx_fill <= rx_resume_lvl)
        auto_rts_q <= 1'b0;
      // Manual level from modem control bits 1 (RTS) and 0 (DTR)
      rts_out_b <= ~mcr_q[`UEFC_BIT_MAN_RTS];
      dtr_out_b <= ~mcr_q[`UEFC_BIT_MAN_DTR];
      if (auto_out && !pair_dsr)
        rts_out_b <= auto_rts_q | ~mcr_q[`UEFC_BIT_MAN_RTS];
      if (auto_out && pair_dsr)
        dtr_out_b <= auto_rts_q | ~mcr_q[`UEFC_BIT_MAN_DTR];
    end
  end

  // Sleep gate: requests are dropped unless enhanced mode is on
  // Not held: sleep ends as soon as the request or the enhanced bit drops
  always @(posedge clk)
  begin
    if (!rst_b)
      sleep_active <= 1'b0;
    else
      sleep_active <= sleep_req & enh;
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always @(posedge clk)
  begin
    if (!rst_b)
      rdata <= `UEFC_RST_BYTE;
    else if (rd)
    begin
      if (addr == `UEFC_OFS_FEAT)
        rdata <= feat_q;
      else if (addr == `UEFC_OFS_IER)
        rdata <= ier_q;
      else if (addr == `UEFC_OFS_ISR)
        rdata <= isr_q;
      else if (addr == `UEFC_OFS_FCR)
        rdata <= fcr_q;
      else if (addr == `UEFC_OFS_MCR)
        rdata <= mcr_q;
      else if (addr == `UEFC_OFS_MSR)
        rdata <= msr_q;
      else if (addr == `UEFC_OFS_ASR)
        rdata <= asr_q;
      else if (addr == `UEFC_OFS_STAT)
        rdata <= {3'h0, sleep_active, auto_rts_q, tx_stall, 2'h0};
      else
        rdata <= `UEFC_RST_BYTE;
    end
    else
      rdata <= `UEFC_RST_BYTE;
  end
endmodule // uefc_top
`default_nettype wire

// >>> rtl/uefc_map.vh
// Overview of operation
// - Eight-bit feature control register, reset zero, host read and write.
// - Bit 7 enables automatic transmit stall from the selected modem input.
// - Modem control bit 2 picks the CTS/RTS pair or the DSR/DTR pair.
// - Bit 6 drives outgoing RTS or DTR from receive FIFO fill level while its manual modem control bit is set.
// - Bit 5: match with second stop char is stored and flags special.
// - If receive flow also compares it, match is flow control, not stored.
// - Enhanced bits of other registers are writable only while bit 4 is set.
// - Sleep entry is permitted only while bit 4 is set.
// - Bits 3:0 select software flow: upper pair transmit, lower pair receive.
`ifndef UEFC_MAP_VH
`define UEFC_MAP_VH
`define UEFC_ADDR_W 4
`define UEFC_OFS_FEAT 4'h9
`define UEFC_OFS_MCR 4'h4
`define UEFC_OFS_ISR 4'h2
`define UEFC_OFS_IER 4'h1
`define UEFC_OFS_FCR 4'h3
`define UEFC_OFS_MSR 4'h6
`define UEFC_OFS_ASR 4'hF
`define UEFC_OFS_STAT 4'hB
`define UEFC_RST_BYTE 8'h00
`define UEFC_BIT_AUTO_IN 7
`define UEFC_BIT_AUTO_OUT 6
`define UEFC_BIT_SPECIAL 5
`define UEFC_BIT_ENH 4
`define UEFC_BIT_PAIRSEL 2
`define UEFC_BIT_SPEC_FLAG 4
`define UEFC_BIT_STOP_FLAG 5
`define UEFC_BIT_RXCMP2 0
`define UEFC_BIT_MAN_RTS 1
`define UEFC_BIT_MAN_DTR 0
`define UEFC_TXSEL_HI 3
`define UEFC_TXSEL_LO 2
`define UEFC_RXSEL_HI 1
`define UEFC_RXSEL_LO 0
`define UEFC_MASK_IER 8'hE0
`define UEFC_MASK_ISR 8'h30
`define UEFC_MASK_FCR 8'h30
`define UEFC_MASK_MCR 8'hEC
`define UEFC_MASK_MSR 8'h0C
`define UEFC_MASK_ASR 8'hFF
`endif

// >>> rtl/uefc_char_match.v
`timescale 1ns/1ns
`default_nettype none
`include "uefc_map.vh"
// Classifies one received character against the second stop character
module uefc_char_match
(
  input wire [7:0] rx_char,
  input wire [7:0] second_stop_char,
  input wire special_en,
  input wire rx_cmp_stop2,
  output wire store,
  output wire special_hit,
  output wire stop_hit
);
  wire eq;
  assign eq = (rx_char == second_stop_char);
  // Flow control takes priority; the character is then consumed
  assign stop_hit = eq & rx_cmp_stop2;
  assign special_hit = eq & special_en;
  assign store = ~stop_hit;
endmodule // uefc_char_match
`default_nettype wire

// >>> verification/uefc_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks; a shadow of the feature byte avoids peeking inside
module uefc_monitor
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic cts_in_b,
  input wire logic dsr_in_b,
  input wire logic tx_stall,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic [7:0] second_stop_char,
  input wire logic rx_store,
  input wire logic rx_flow_stop,
  input wire logic sleep_req,
  input wire logic sleep_active
);
  logic [7:0] f_q;
  logic hit;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shadow follows host writes to the feature byte
  always_ff @(posedge clk)
  begin
    if (!rst_b) f_q <= 8'h00;
    else if (wr && addr == 4'h9) f_q <= wdata;
  end
  assign hit = rx_valid && rx_char == second_stop_char;
  property p_rd; rd && addr == 4'h9 |=> rdata == $past(f_q); endproperty
  a_rd: assert property (p_rd) else $error("feature readback");
  property p_off; !f_q[7] |-> !tx_stall; endproperty
  a_off: assert property (p_off) else $error("stall while off");
  property p_on; f_q[7] && cts_in_b && dsr_in_b |-> tx_stall; endproperty
  a_on: assert property (p_on) else $error("no stall");
  property p_rdy; f_q[7] && !cts_in_b && !dsr_in_b |-> !tx_stall; endproperty
  a_rdy: assert property (p_rdy) else $error("stall when ready");
  property p_slp; sleep_req && f_q[4] |=> sleep_active; endproperty
  a_slp: assert property (p_slp) else $error("sleep refused");
  property p_nsl; !f_q[4] |=> !sleep_active; endproperty
  a_nsl: assert property (p_nsl) else $error("sleep not gated");
  property p_sp; hit && f_q[5] && !f_q[0] |=> rx_store; endproperty
  a_sp: assert property (p_sp) else $error("match not stored");
  property p_fl; hit && f_q[0] |=> !rx_store && rx_flow_stop; endproperty
  a_fl: assert property (p_fl) else $error("flow char stored");
  c_stall: cover property (tx_stall);
  c_flow: cover property (rx_flow_stop);
  c_sleep: cover property (sleep_active);
endmodule // uefc_monitor
bind uefc_top uefc_monitor mon (.clk, .rst_b, .addr, .wdata, .wr, .rd,
  .rdata, .cts_in_b, .dsr_in_b, .tx_stall, .rx_valid, .rx_char,
  .second_stop_char, .rx_store, .rx_flow_stop, .sleep_req, .sleep_active);
`default_nettype wire

// >>> verification/uefc_remote.sv
`timescale 1ns/1ns
`default_nettype none
// Remote modem end; a low ready line means it can take data
module uefc_remote
(
  input wire logic cts_busy,
  input wire logic dsr_busy,
  input wire logic rts_out_b,
  output logic cts_in_b,
  output logic dsr_in_b,
  output logic halted
);
  // Levels only, so the remote answers at once or stalls as told
  assign cts_in_b = cts_busy;
  assign dsr_in_b = dsr_busy;
  assign halted = rts_out_b;
endmodule // uefc_remote
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic rx_valid = 1'b0, sleep_req = 1'b0, cb = 1'b0, db = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rx_char = 8'h00, rdata, d;
  logic [7:0] xc = 8'h13, sd;
  logic [6:0] rx_fill = 7'h00;
  logic cts_in_b, dsr_in_b, rts_out_b, dtr_out_b, tx_stall, halted;
  logic rx_store, rx_flow_stop, sleep_active;
  logic [1:0] tx_flow_sel, rx_flow_sel;
  logic [7:0] q[$];
  logic [31:0] seed = 32'ha37e;
  int error_cnt = 0, samples_checked = 0, cyc = 0, i;
  uefc_top uut (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .cts_in_b,
    .dsr_in_b, .rts_out_b, .dtr_out_b, .tx_stall, .rx_fill,
    .rx_halt_lvl(7'h20), .rx_resume_lvl(7'h10), .rx_valid, .rx_char,
    .second_stop_char(xc), .rx_store, .rx_store_data(sd), .rx_flow_stop,
    .sleep_req, .sleep_active, .tx_flow_sel, .rx_flow_sel);
  uefc_remote far (.cts_busy(cb), .dsr_busy(db), .rts_out_b, .cts_in_b,
    .dsr_in_b, .halted);
  always #20 clk = ~clk;
  task print_verdict;
    $display("checked %0d bad %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One-cycle strobe; reads leave their expected byte in the queue
  task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    if (!w) q.push_back(v);
  endtask
  task idle;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    rx_valid <= 1'b0;
    #1;
  endtask
  task rxc(input logic [7:0] c);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    rx_valid <= 1'b1;
    rx_char <= c;
    idle;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rd_d) check(rdata, q.pop_front());
    rd_d <= rd;
    if (cyc == 3000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    xc <= 8'($random(seed));
    bus(0, 4'h9, 8'h00);
    bus(0, 4'hA, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      bus(1, 4'h9, d);
      bus(0, 4'h9, d);
    end
    // Guarded modem bits hold until the enhanced bit opens them
    bus(1, 4'h9, 8'h00);
    bus(1, 4'h4, 8'hFF);
    bus(0, 4'h4, 8'h13);
    bus(1, 4'h9, 8'h90);
    bus(1, 4'h4, 8'hEC);
    bus(0, 4'h4, 8'hEC);
    cb <= 1'b1;
    idle;
    $display("register test done");
    check(tx_stall, 8'h00);
    db <= 1'b1;
    idle;
    check(tx_stall, 8'h01);
    db <= 1'b0;
    bus(1, 4'h4, 8'h00);
    idle;
    check(tx_stall, 8'h01);
    bus(1, 4'h9, 8'h10);
    sleep_req <= 1'b1;
    idle;
    check(tx_stall, 8'h00);
    idle;
    check(sleep_active, 8'h01);
    bus(1, 4'h9, 8'h20);
    idle;
    idle;
    check(sleep_active, 8'h00);
    $display("flow and sleep test done");
    rxc(xc);
    check(rx_store, 8'h01);
    check(sd, xc);
    bus(0, 4'h2, 8'h10);
    bus(1, 4'h9, 8'h21);
    rxc(xc);
    check({rx_store, rx_flow_stop}, 8'h01);
    bus(0, 4'h2, 8'h30);
    rxc(xc ^ 8'h5A);
    check({rx_store, rx_flow_stop}, 8'h02);
    // Clear the sticky flags under the unlock bit, then lock again
    bus(1, 4'h9, 8'h10);
    bus(1, 4'h2, 8'h00);
    bus(1, 4'h9, 8'h00);
    rxc(xc);
    check(rx_store, 8'h01);
    bus(0, 4'h2, 8'h00);
    // Manual request asserted, so only the fill level can drop it
    bus(1, 4'h4, 8'h02);
    bus(1, 4'h9, 8'h4B);
    idle;
    idle;
    check(halted, 8'h00);
    rx_fill <= 7'h30;
    idle;
    idle;
    idle;
    check({tx_flow_sel, rx_flow_sel}, 8'h0B);
    check(halted, 8'h01);
    bus(1, 4'h9, 8'h5B);
    bus(1, 4'h4, 8'h05);
    rx_fill <= 7'h00;
    idle;
    idle;
    idle;
    check({rts_out_b, dtr_out_b}, 8'h02);
    rx_fill <= 7'h30;
    idle;
    idle;
    check(dtr_out_b, 8'h01);
    $display("receive test done");
    idle;
    print_verdict;
  end
endmodule // tb
`default_nettype wire
